// ==== mrc_pkg.sv ====
// Behaviour
// - The 8-bit target setpoint register value is passed on as the regulation target, voltage or ripple speed by mode.
// - The 2-bit filter code selects an output voltage filter cut-off of 250, 500, 750 or 1000 Hz.
// - The programmed 6-bit duty drives the bridge only while regulation is off and the duty source select is 1.
// - The programmed duty maps linearly from 0% at code 0 to 100% at code 63.
// - The inverse resistance scale code gives a factor of 2, 64, 1024 or 8192.
// - The back-EMF scale code gives 24 times 2 to the power 8, 9, 12 or 13.
// - The 8-bit back-EMF constant is passed on together with its selected scale.
// - The 3-bit proportional divider code gives 32, 64, 128, 256, 512, 16 or 1.
// - The proportional gain applied is the 5-bit multiplier over the decoded divider.
package mrc_pkg;
  // Register offsets as seen over the serial port
  localparam logic [7:0] OFS_TARGET = 8'h0f;
  localparam logic [7:0] OFS_FILT_DUTY = 8'h10;
  localparam logic [7:0] OFS_RSV_A = 8'h11;
  localparam logic [7:0] OFS_RSV_B = 8'h12;
  localparam logic [7:0] OFS_SCALING = 8'h13;
  localparam logic [7:0] OFS_INVERSE_RESISTANCE = 8'h14;
  localparam logic [7:0] OFS_BEMF = 8'h15;
  localparam logic [7:0] OFS_RSV_C = 8'h16;
  localparam logic [7:0] OFS_RSV_D = 8'h17;
  localparam logic [7:0] OFS_PGAIN = 8'h18;
  // Reset values
  localparam logic [7:0] RST_TARGET = 8'hff;
  localparam logic [7:0] RST_FILT_DUTY = 8'h00;
  localparam logic [7:0] RST_RSV_A = 8'h01;
  localparam logic [7:0] RST_RSV_B = 8'hff;
  localparam logic [7:0] RST_SCALING = 8'h73;
  localparam logic [7:0] RST_INVERSE_RESISTANCE = 8'h00;
  localparam logic [7:0] RST_BEMF = 8'h00;
  localparam logic [7:0] RST_RSV_C = 8'h00;
  localparam logic [7:0] RST_RSV_D = 8'h00;
  localparam logic [7:0] RST_PGAIN = 8'h21;
  // Field positions (low bit of each field)
  localparam int FLT_LSB = 6;
  localparam int DUTY_LSB = 0;
  localparam int IRS_LSB = 6;
  localparam int BES_LSB = 4;
  localparam int PDIV_LSB = 5;
  localparam int PMUL_LSB = 0;
  localparam logic [2:0] PDIV_RESERVED = 3'h7;
  // Timing: PWM carrier built from 63 duty steps
  localparam int CLK_HZ = 125_000_000;
  localparam int PWM_FREQ_HZ = 20_000;
  localparam logic [5:0] DUTY_FULL = 6'h3f;
  localparam int PWM_TICK_CYC = CLK_HZ / (PWM_FREQ_HZ * 63);
  // Serial target states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ADDR_ACK = 4'h2, ST_PTR = 4'h3, ST_PTR_ACK = 4'h4,
    ST_WDATA = 4'h5, ST_WDATA_ACK = 4'h6, ST_RDATA = 4'h7, ST_RDATA_ACK = 4'h8
  } mrc_i2c_state_t;

  function automatic logic [10:0] filter_hz(input logic [1:0] code);
    case (code)
      2'h0: filter_hz = 11'd250;
      2'h1: filter_hz = 11'd500;
      2'h2: filter_hz = 11'd750;
      default: filter_hz = 11'd1000;
    endcase
  endfunction

  function automatic logic [13:0] inverse_resistance_scale(input logic [1:0] code);
    case (code)
      2'h0: inverse_resistance_scale = 14'd2;
      2'h1: inverse_resistance_scale = 14'd64;
      2'h2: inverse_resistance_scale = 14'd1024;
      default: inverse_resistance_scale = 14'd8192;
    endcase
  endfunction

  function automatic logic [17:0] bemf_scale(input logic [1:0] code);
    case (code)
      2'h0: bemf_scale = 18'd24 << 8;
      2'h1: bemf_scale = 18'd24 << 9;
      2'h2: bemf_scale = 18'd24 << 12;
      default: bemf_scale = 18'd24 << 13;
    endcase
  endfunction

  function automatic logic [9:0] proportional_divider(input logic [2:0] code);
    case (code)
      3'h0: proportional_divider = 10'd32;
      3'h1: proportional_divider = 10'd64;
      3'h2: proportional_divider = 10'd128;
      3'h3: proportional_divider = 10'd256;
      3'h4: proportional_divider = 10'd512;
      3'h5: proportional_divider = 10'd16;
      default: proportional_divider = 10'd1;
    endcase
  endfunction
endpackage

// ==== mrc_i2c_target.sv ====
`timescale 1ns/1ns
module mrc_i2c_target
  import mrc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30 // Arbitrary default target address
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_oe,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  mrc_i2c_state_t state;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [3:0] cnt;
  logic rw;
  logic nack;
  logic [7:0] ptr;

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[1] == scl_s[2]) begin
        scl_q <= scl_s[2];
      end
      if (sda_s[1] == sda_s[2]) begin
        sda_q <= sda_s[2];
      end
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_prev;
  assign scl_fall = !scl_q && scl_prev;
  assign start_c = scl_q && scl_prev && sda_prev && !sda_q;
  assign stop_c = scl_q && scl_prev && !sda_prev && sda_q;
  assign rd_addr = ptr;

  // Byte engine: sample on SCL rise, change SDA only on SCL fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      nack <= 1'b0;
      ptr <= 8'h00;
      sda_oe <= 1'b0;
      wr_en <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_c) begin
        state <= ST_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == ST_ADDR || state == ST_PTR || state == ST_WDATA) begin
          shift <= {shift[6:0], sda_q};
          cnt <= cnt + 4'h1;
        end else if (state == ST_RDATA) begin
          cnt <= cnt + 4'h1;
        end else if (state == ST_RDATA_ACK) begin
          nack <= sda_q;
          if (!sda_q) begin
            ptr <= ptr + 8'h01; // Advance early so the next byte is ready by the fall
          end
        end
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (cnt == 4'h8) begin
              if (shift[7:1] == DEV_ADDR) begin
                state <= ST_ADDR_ACK;
                rw <= shift[0];
                sda_oe <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              state <= ST_RDATA;
              tx <= rd_data;
              sda_oe <= !rd_data[7];
            end else begin
              state <= ST_PTR;
              sda_oe <= 1'b0;
            end
          end
          ST_PTR: begin
            if (cnt == 4'h8) begin
              ptr <= shift;
              state <= ST_PTR_ACK;
              sda_oe <= 1'b1;
            end
          end
          ST_WDATA: begin
            if (cnt == 4'h8) begin
              wr_en <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shift;
              state <= ST_WDATA_ACK;
              sda_oe <= 1'b1;
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            if (state == ST_WDATA_ACK) begin
              ptr <= ptr + 8'h01;
            end
            cnt <= 4'h0;
            state <= ST_WDATA;
            sda_oe <= 1'b0;
          end
          ST_RDATA: begin
            if (cnt == 4'h8) begin
              state <= ST_RDATA_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= !tx[3'h7 - cnt[2:0]];
            end
          end
          ST_RDATA_ACK: begin
            cnt <= 4'h0;
            if (nack) begin
              state <= ST_IDLE;
              sda_oe <= 1'b0;
            end else begin
              state <= ST_RDATA;
              tx <= rd_data;
              sda_oe <= !rd_data[7];
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ==== mrc_regs.sv ====
`timescale 1ns/1ns
module mrc_regs
  import mrc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30 // Arbitrary default target address
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic REGULATION_ACTIVE,
  input wire logic DUTY_SOURCE_SEL,
  input wire logic [5:0] LOOP_DUTY,
  output logic [7:0] TARGET_SETPOINT,
  output logic [10:0] FILTER_CUTOFF_HZ,
  output logic PROGRAMMED_DUTY_ACTIVE,
  output logic [5:0] BRIDGE_DUTY,
  output logic PWM_OUT,
  output logic [13:0] INVERSE_RESISTANCE_SCALE_FACTOR,
  output logic [7:0] INVERSE_RESISTANCE,
  output logic INVERSE_RESISTANCE_ZERO,
  output logic [17:0] BEMF_SCALE_FACTOR,
  output logic [7:0] BACK_EMF_CONSTANT,
  output logic [4:0] KP_MULTIPLIER,
  output logic [9:0] KP_DIVIDER
);
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] rg_target;
  logic [7:0] rg_filt_duty;
  logic [7:0] rg_scaling;
  logic [7:0] rg_inverse_resistance;
  logic [7:0] rg_bemf;
  logic [7:0] rg_pgain;
  logic [6:0] tick_cnt;
  logic pwm_tick;
  logic [5:0] pwm_cnt;
  logic prog_sel;

  mrc_i2c_target #(.DEV_ADDR(DEV_ADDR)) u_i2c (
    .clk(MCLK),
    .rst_n(RST_N),
    .scl(SCL),
    .sda_i(SDA_I),
    .sda_oe(SDA_OE),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Open drain: the pin is only ever pulled low
  assign SDA_O = 1'b0;

  // Writable registers; reserved slots ignore writes so hidden trims stay at their reset values
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rg_target <= RST_TARGET;
      rg_filt_duty <= RST_FILT_DUTY;
      rg_scaling <= RST_SCALING;
      rg_inverse_resistance <= RST_INVERSE_RESISTANCE;
      rg_bemf <= RST_BEMF;
      rg_pgain <= RST_PGAIN;
    end else if (wr_en) begin
      if (wr_addr == OFS_TARGET) begin
        rg_target <= wr_data;
      end else if (wr_addr == OFS_FILT_DUTY) begin
        rg_filt_duty <= wr_data;
      end else if (wr_addr == OFS_SCALING) begin
        rg_scaling <= wr_data;
      end else if (wr_addr == OFS_INVERSE_RESISTANCE) begin
        rg_inverse_resistance <= wr_data;
      end else if (wr_addr == OFS_BEMF) begin
        rg_bemf <= wr_data;
      end else if (wr_addr == OFS_PGAIN) begin
        rg_pgain <= wr_data;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    if (rd_addr == OFS_TARGET) begin
      rd_data = rg_target;
    end else if (rd_addr == OFS_FILT_DUTY) begin
      rd_data = rg_filt_duty;
    end else if (rd_addr == OFS_RSV_A) begin
      rd_data = RST_RSV_A;
    end else if (rd_addr == OFS_RSV_B) begin
      rd_data = RST_RSV_B;
    end else if (rd_addr == OFS_SCALING) begin
      rd_data = rg_scaling;
    end else if (rd_addr == OFS_INVERSE_RESISTANCE) begin
      rd_data = rg_inverse_resistance;
    end else if (rd_addr == OFS_BEMF) begin
      rd_data = rg_bemf;
    end else if (rd_addr == OFS_RSV_C) begin
      rd_data = RST_RSV_C;
    end else if (rd_addr == OFS_RSV_D) begin
      rd_data = RST_RSV_D;
    end else if (rd_addr == OFS_PGAIN) begin
      rd_data = rg_pgain;
    end else begin
      rd_data = 8'h00;
    end
  end

  // Decoded configuration towards the regulation loop
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      TARGET_SETPOINT <= RST_TARGET;
      FILTER_CUTOFF_HZ <= filter_hz(RST_FILT_DUTY[FLT_LSB +: 2]);
      INVERSE_RESISTANCE_SCALE_FACTOR <= inverse_resistance_scale(RST_SCALING[IRS_LSB +: 2]);
      BEMF_SCALE_FACTOR <= bemf_scale(RST_SCALING[BES_LSB +: 2]);
      INVERSE_RESISTANCE <= RST_INVERSE_RESISTANCE;
      INVERSE_RESISTANCE_ZERO <= (RST_INVERSE_RESISTANCE == 8'h00);
      BACK_EMF_CONSTANT <= RST_BEMF;
    end else begin
      TARGET_SETPOINT <= rg_target;
      FILTER_CUTOFF_HZ <= filter_hz(rg_filt_duty[FLT_LSB +: 2]);
      INVERSE_RESISTANCE_SCALE_FACTOR <= inverse_resistance_scale(rg_scaling[IRS_LSB +: 2]);
      BEMF_SCALE_FACTOR <= bemf_scale(rg_scaling[BES_LSB +: 2]);
      INVERSE_RESISTANCE <= rg_inverse_resistance;
      INVERSE_RESISTANCE_ZERO <= (rg_inverse_resistance == 8'h00); // Flags a forbidden zero
      BACK_EMF_CONSTANT <= rg_bemf;
    end
  end

  // Proportional gain; code 111 has no divider, so the last valid one is kept
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      KP_MULTIPLIER <= RST_PGAIN[PMUL_LSB +: 5];
      KP_DIVIDER <= proportional_divider(RST_PGAIN[PDIV_LSB +: 3]);
    end else begin
      KP_MULTIPLIER <= rg_pgain[PMUL_LSB +: 5];
      if (rg_pgain[PDIV_LSB +: 3] != PDIV_RESERVED) begin
        KP_DIVIDER <= proportional_divider(rg_pgain[PDIV_LSB +: 3]);
      end
    end
  end

  // Duty source; mode inputs come from same-clock logic, so no synchroniser
  assign prog_sel = !REGULATION_ACTIVE && DUTY_SOURCE_SEL;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      PROGRAMMED_DUTY_ACTIVE <= 1'b0;
      BRIDGE_DUTY <= 6'h00;
    end else begin
      PROGRAMMED_DUTY_ACTIVE <= prog_sel;
      BRIDGE_DUTY <= prog_sel ? rg_filt_duty[DUTY_LSB +: 6] : LOOP_DUTY;
    end
  end

  // Step enable for the PWM carrier
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tick_cnt <= 7'h00;
      pwm_tick <= 1'b0;
    end else if (tick_cnt == 7'(PWM_TICK_CYC - 1)) begin
      tick_cnt <= 7'h00;
      pwm_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 7'h01;
      pwm_tick <= 1'b0;
    end
  end

  // 63-step carrier: code 0 never high, code 63 always high, linear between
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pwm_cnt <= 6'h00;
      PWM_OUT <= 1'b0;
    end else begin
      if (pwm_tick) begin
        pwm_cnt <= (pwm_cnt == DUTY_FULL - 6'h01) ? 6'h00 : pwm_cnt + 6'h01;
      end
      PWM_OUT <= (pwm_cnt < BRIDGE_DUTY);
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  property p_target;
    ##1 TARGET_SETPOINT == $past(rg_target);
  endproperty
  a_target: assert property (p_target) else $error("setpoint not passed on");

  property p_filter;
    (rg_filt_duty[7:6] == 2'h2) |=> (FILTER_CUTOFF_HZ == 11'd750);
  endproperty
  a_filter: assert property (p_filter) else $error("filter cut-off decode wrong");

  property p_programmed_duty;
    (!REGULATION_ACTIVE && DUTY_SOURCE_SEL) |=> PROGRAMMED_DUTY_ACTIVE && BRIDGE_DUTY == $past(rg_filt_duty[5:0]);
  endproperty
  a_programmed_duty: assert property (p_programmed_duty) else $error("programmed duty not applied");

  property p_loop_duty;
    (REGULATION_ACTIVE || !DUTY_SOURCE_SEL) |=> !PROGRAMMED_DUTY_ACTIVE && BRIDGE_DUTY == $past(LOOP_DUTY);
  endproperty
  a_loop_duty: assert property (p_loop_duty) else $error("programmed duty used while not selected");

  property p_duty_zero;
    (BRIDGE_DUTY == 6'h00) |=> !PWM_OUT;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty produced a high output");

  property p_duty_full;
    (BRIDGE_DUTY == 6'h3f) [*2] |=> PWM_OUT;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty produced a low output");

  property p_inv_scale;
    (rg_scaling[7:6] == 2'h3) |=> (INVERSE_RESISTANCE_SCALE_FACTOR == 14'd8192);
  endproperty
  a_inv_scale: assert property (p_inv_scale) else $error("inverse resistance scale wrong");

  property p_bemf_scale;
    (rg_scaling[5:4] == 2'h1) |=> (BEMF_SCALE_FACTOR == 18'd12288);
  endproperty
  a_bemf_scale: assert property (p_bemf_scale) else $error("back-EMF scale wrong");

  property p_bemf_const;
    $changed(rg_bemf) |-> ##1 BACK_EMF_CONSTANT == $past(rg_bemf);
  endproperty
  a_bemf_const: assert property (p_bemf_const) else $error("back-EMF constant not passed on");

  property p_proportional_divider;
    (rg_pgain[7:5] == 3'h5) |=> (KP_DIVIDER == 10'd16);
  endproperty
  a_proportional_divider: assert property (p_proportional_divider) else $error("proportional divider decode wrong");

  property p_proportional_multiplier;
    ##1 KP_MULTIPLIER == $past(rg_pgain[4:0]);
  endproperty
  a_proportional_multiplier: assert property (p_proportional_multiplier) else $error("proportional multiplier not passed on");

  property p_kp_hold;
    (rg_pgain[7:5] == 3'h7) |=> $stable(KP_DIVIDER);
  endproperty
  a_kp_hold: assert property (p_kp_hold) else $error("reserved divider code changed the gain");

  c_write: cover property (wr_en && wr_addr == OFS_PGAIN);
  c_prog: cover property (PROGRAMMED_DUTY_ACTIVE && PWM_OUT);
  c_hold: cover property (rg_pgain[7:5] == 3'h7);
endmodule

// ==== test_motor_regulation_config.sv ====
`timescale 1ns/1ns
module test_motor_regulation_config
  import mrc_pkg::*;
;
  localparam logic [6:0] ADDR = 7'h30; // Arbitrary target address
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic reg_act = 1'b1;
  logic duty_sel = 1'b0;
  logic [5:0] loop_duty = 6'h00;
  logic sda_o, sda_oe, pda, pwm_out, inverse_resistance_zero;
  logic [7:0] target, inverse_resistance, bemf_const;
  logic [10:0] filt_hz;
  logic [5:0] bridge;
  logic [13:0] irs;
  logic [17:0] bes;
  logic [4:0] proportional_multiplier;
  logic [9:0] proportional_divider;
  int errors = 0;
  int cmp_count = 0;
  int irs_sh [4] = '{1, 6, 10, 13};
  int bes_sh [4] = '{8, 9, 12, 13};
  int div_tab [7] = '{32, 64, 128, 256, 512, 16, 1};
  logic [7:0] rst_tab [11] = '{8'hff, 8'h00, 8'h01, 8'hff, 8'h73, 8'h00, 8'h00, 8'h00, 8'h00, 8'h21, 8'h00};
  // Open-drain wire with pull-up: the device only ever pulls low
  wire sda_w = sda_oe ? sda_o : sda_m;

  mrc_regs #(.DEV_ADDR(ADDR)) dut (
    .MCLK(mclk),
    .RST_N(rst_n),
    .SCL(scl),
    .SDA_I(sda_w),
    .SDA_O(sda_o),
    .SDA_OE(sda_oe),
    .REGULATION_ACTIVE(reg_act),
    .DUTY_SOURCE_SEL(duty_sel),
    .LOOP_DUTY(loop_duty),
    .TARGET_SETPOINT(target),
    .FILTER_CUTOFF_HZ(filt_hz),
    .PROGRAMMED_DUTY_ACTIVE(pda),
    .BRIDGE_DUTY(bridge),
    .PWM_OUT(pwm_out),
    .INVERSE_RESISTANCE_SCALE_FACTOR(irs),
    .INVERSE_RESISTANCE(inverse_resistance),
    .INVERSE_RESISTANCE_ZERO(inverse_resistance_zero),
    .BEMF_SCALE_FACTOR(bes),
    .BACK_EMF_CONSTANT(bemf_const),
    .KP_MULTIPLIER(proportional_multiplier),
    .KP_DIVIDER(proportional_divider)
  );

  // 125 MHz clock
  always #4 mclk = ~mclk;

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Half periods of 12 MCLK keep clear of the three-stage pin synchroniser
  task automatic i2c_bit(input logic b, output logic r);
    sda_m <= b;
    wait_cyc(6);
    scl <= 1'b1;
    wait_cyc(12);
    r = sda_w;
    scl <= 1'b0;
    wait_cyc(6);
  endtask

  task automatic i2c_start();
    sda_m <= 1'b1;
    scl <= 1'b1;
    wait_cyc(12);
    sda_m <= 1'b0;
    wait_cyc(12);
    scl <= 1'b0;
    wait_cyc(6);
  endtask

  task automatic i2c_stop();
    sda_m <= 1'b0;
    wait_cyc(6);
    scl <= 1'b1;
    wait_cyc(12);
    sda_m <= 1'b1;
    wait_cyc(12);
  endtask

  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask

  // Master answers ACK to ask for another byte, NACK after the last one
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, d[i]);
    i2c_bit(last, r);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic k;
    i2c_start();
    tx({ADDR, 1'b0}, k);
    chk(32'(k), 32'h1);
    tx(a, k);
    chk(32'(k), 32'h1);
    tx(d, k);
    chk(32'(k), 32'h1);
    i2c_stop();
    wait_cyc(4);
  endtask

  // Pointer set in its own frame, then a separate read frame
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic k;
    i2c_start();
    tx({ADDR, 1'b0}, k);
    tx(a, k);
    i2c_stop();
    i2c_start();
    tx({ADDR, 1'b1}, k);
    chk(32'(k), 32'h1);
    rx(1'b1, d);
    i2c_stop();
    wait_cyc(4);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    chk(32'(target), 32'hff);
    chk(32'(filt_hz), 32'd250);
    chk(32'(bridge), 32'h0);
    chk(32'(irs), 32'd64);
    chk(32'(bes), 32'd24 << 13);
    chk(32'(inverse_resistance_zero), 32'h1);
    chk(32'(proportional_divider), 32'd64);
    chk(32'(proportional_multiplier), 32'h1);
    // Offsets 0x0f to 0x18, then 0x19 which is unmapped here
    for (int i = 0; i < 11; i++) begin
      reg_read(OFS_TARGET + 8'(i), d);
      chk(32'(d), 32'(rst_tab[i]));
    end
  endtask

  task automatic t_refuse();
    logic [7:0] d;
    logic k;
    reg_write(OFS_RSV_A, 8'h55);
    reg_read(OFS_RSV_A, d);
    chk(32'(d), 32'h01);
    // Foreign address must not be acknowledged
    i2c_start();
    tx({ADDR ^ 7'h01, 1'b0}, k);
    chk(32'(k), 32'h0);
    i2c_stop();
  endtask

  task automatic t_filter_target();
    reg_write(OFS_TARGET, 8'h5a);
    chk(32'(target), 32'h5a);
    for (int c = 0; c < 4; c++) begin
      reg_write(OFS_FILT_DUTY, {c[1:0], 6'h2a}); // All codes stay 20 times under the carrier
      chk(32'(filt_hz), 32'(250 * (c + 1)));
    end
  endtask

  // Case 0 selects the programmed duty; the other two fall back to the loop
  task automatic t_duty_sel();
    loop_duty <= 6'h11;
    for (int i = 0; i < 3; i++) begin
      reg_act <= (i == 1);
      duty_sel <= (i != 2);
      wait_cyc(3);
      chk(32'(pda), 32'(i == 0));
      chk(32'(bridge), (i == 0) ? 32'h2a : 32'h11);
    end
  endtask

  // Count high cycles over one full carrier period, after one period to settle
  task automatic t_pwm();
    int d;
    int h;
    int u;
    reg_act <= 1'b0;
    duty_sel <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      d = (j == 0) ? 0 : ((j == 1) ? 21 : 63);
      reg_write(OFS_FILT_DUTY, {2'b00, 6'(d)}); // 250 Hz filter, far under the carrier
      wait_cyc(6300);
      h = 0;
      u = 0;
      repeat (6237) begin
        @(posedge mclk);
        if (pwm_out === 1'b1) h++;
        else if (pwm_out !== 1'b0) u++;
      end
      chk(32'(h), 32'(d * 99));
      chk(32'(u), 32'h0); // Unknown output must not hide as low
    end
  endtask

  task automatic t_scale();
    for (int c = 0; c < 4; c++) begin
      reg_write(OFS_SCALING, {c[1:0], c[1:0], 4'h3});
      chk(32'(irs), 32'h1 << irs_sh[c]);
      chk(32'(bes), 32'd24 << bes_sh[c]);
    end
    // Software never loads zero; the zero flag was already seen set out of reset
    reg_write(OFS_INVERSE_RESISTANCE, 8'h3c);
    chk(32'(inverse_resistance), 32'h3c);
    chk(32'(inverse_resistance_zero), 32'h0);
    reg_write(OFS_BEMF, 8'hc5);
    chk(32'(bemf_const), 32'hc5);
  endtask

  // Two-byte write then two-byte read; the pointer steps after every written byte and every ACKed read byte
  task automatic t_burst();
    logic [7:0] d;
    logic k;
    i2c_start();
    tx({ADDR, 1'b0}, k);
    tx(OFS_INVERSE_RESISTANCE, k);
    tx(8'h47, k); // Nonzero
    tx(8'h9c, k);
    chk(32'(k), 32'h1);
    i2c_stop();
    wait_cyc(4);
    chk(32'(inverse_resistance), 32'h47);
    chk(32'(bemf_const), 32'h9c);
    i2c_start();
    tx({ADDR, 1'b0}, k);
    tx(OFS_INVERSE_RESISTANCE, k);
    i2c_stop();
    i2c_start();
    tx({ADDR, 1'b1}, k);
    rx(1'b0, d);
    chk(32'(d), 32'h47);
    rx(1'b1, d);
    chk(32'(d), 32'h9c);
    i2c_stop();
    wait_cyc(4);
  endtask

  task automatic t_gain();
    logic [7:0] d;
    for (int c = 0; c < 7; c++) begin
      reg_write(OFS_PGAIN, {c[2:0], 5'(c + 3)});
      chk(32'(proportional_divider), 32'(div_tab[c]));
      chk(32'(proportional_multiplier), 32'(c + 3));
    end
    // Divider 16 first, so that a reserved code falling through to 1 would show
    reg_write(OFS_PGAIN, 8'ha4);
    chk(32'(proportional_divider), 32'd16);
    reg_write(OFS_PGAIN, 8'hff);
    chk(32'(proportional_divider), 32'd16);
    chk(32'(proportional_multiplier), 32'h1f);
    reg_read(OFS_PGAIN, d);
    chk(32'(d), 32'hff);
  endtask

  // Main sequence: reset held five cycles, then synchroniser settle time
  initial begin
    wait_cyc(5);
    rst_n <= 1'b1;
    wait_cyc(4);
    t_reset();
    t_refuse();
    t_filter_target();
    t_duty_sel();
    t_scale();
    t_burst();
    t_gain();
    t_pwm();
    print_verdict();
  end

  // Watchdog so that a stuck sequence still reaches the verdict
  initial begin
    repeat (95000) @(posedge mclk);
    errors++;
    print_verdict();
  end
endmodule
